/* File: jtx_consts.vh */
// constants for the serial lane transmitter: register map, fields, resets, control characters
`ifndef JTX_CONSTS_VH
`define JTX_CONSTS_VH
// register addresses on the serial register port (7-bit address)
`define JTX_ADDR_PATTERN 7'h26
`define JTX_ADDR_LINK 7'h27
`define JTX_ADDR_KCFG 7'h28
`define JTX_ADDR_STATUS 7'h29
`define JTX_ADDR_ALIGN 7'h38
// register reset values
`define JTX_RST_PATTERN 8'h00
`define JTX_RST_LINK 8'h09
`define JTX_RST_KCFG 8'h1F
`define JTX_RST_ALIGN 8'h00
// field positions
`define JTX_PAT_MSB 7
`define JTX_PAT_LSB 6
`define JTX_LINK_SUB_MSB 1
`define JTX_LINK_SUB_LSB 0
`define JTX_LINK_SCR 2
`define JTX_LINK_FOUR 3
`define JTX_KCFG_MSB 4
`define JTX_ALIGN_FORCE 7
`define JTX_ALIGN_INIT_MSB 6
`define JTX_ALIGN_INIT_LSB 2
`define JTX_ALIGN_DLY_MSB 1
`define JTX_ALIGN_DLY_LSB 0
// test pattern selections and words
`define JTX_PAT_CLOCK 2'h1
`define JTX_PAT_ENCODED 2'h2
`define JTX_PAT_PRBS 2'h3
`define JTX_CLOCK_WORD 16'hAAAA
`define JTX_ENCODED_WORD 16'hF00F
`define JTX_PRBS_SEED 15'h7FFF
// control characters (K28.5, K28.0, K28.3, K28.4)
`define JTX_K_COMMA 8'hBC
`define JTX_K_START 8'h1C
`define JTX_K_END 8'h7C
`define JTX_K_CFG 8'h9C
// alignment sequence layout
`define JTX_ILAS_LAST_MF 2'h3
`define JTX_CFG_MF 2'h1
`define JTX_CFG_FIRST 6'h02
`define JTX_CFG_LAST 6'h0F
// link parameters carried in the configuration octets (ids arbitrary)
`define JTX_DID 8'h00
`define JTX_BID 8'h00
`define JTX_M_M1 8'h01
`define JTX_N_M1 8'h0F
`define JTX_NP_M1 8'h0F
`define JTX_JESDV 8'h01
`define JTX_S_M1 8'h00
`endif

/* File: jtx_link_tx.v */
// serial lane transmitter: transport mapping, scrambler, 8b/10b, sync and lane alignment
// How it works
// R1: subclass 0, 1 and 2 timing supported
// R2: sysref or sync pulse realigns multiframe clock
// R3: two or four lanes enabled per format
// R4: transport maps samples or test patterns
// R5: every octet leaves 8b/10b encoded
// R6: optional scrambler, bypass passes octets straight
// R7: sync high sends commas on all enabled lanes
// R8: sync low starts alignment at multiframe boundary
// R9: alignment lasts four multiframes of K frames
// R10: start/end symbols, config data in second
// R11: two pattern bits select three test patterns
// R12: formats L4 F1 and L2 F2 mapped
// R13: lane rate is ten times octet rate
// R14: multiframe clock spans K frame periods
// R15: two bits delay alignment zero-three multiframes
// R16: sysref zeroes counter, commas stop at wrap
// R17: force bit reloads counter from start value
`include "jtx_consts.vh"
`timescale 1ns/100ps
`default_nettype none

module jtx_link_tx (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // converter samples, sampling clock domain
  input wire [15:0] adc_a_i,
  input wire [15:0] adc_b_i,
  // alignment pins
  input wire sysref_i,
  input wire sync_i,
  // serial register port
  input wire sclk_i,
  input wire sdata_i,
  input wire sen_n_i,
  output reg sdout_o,
  // lanes: ten-bit symbols, bit 0 sent first
  output wire [39:0] lane_sym_o,
  output wire [3:0] lane_en_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg sclk_m, sclk_s, sclk_d; // serial clock chain plus edge history
  reg sdata_m, sdata_s; // serial data chain
  reg sen_m, sen_s; // serial enable chain, low active
  reg sysref_m, sysref_s, sysref_d; // sysref chain
  reg sync_m, sync_s, sync_d; // sync request chain

  // two flops per pin, third flop only for edge detection
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      sdata_m <= 1'b0;
      sdata_s <= 1'b0;
      sen_m <= 1'b1;
      sen_s <= 1'b1;
      sysref_m <= 1'b0;
      sysref_s <= 1'b0;
      sysref_d <= 1'b0;
      sync_m <= 1'b0;
      sync_s <= 1'b0;
      sync_d <= 1'b0;
    end
    else
    begin
      sclk_m <= sclk_i;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      sdata_m <= sdata_i;
      sdata_s <= sdata_m;
      sen_m <= sen_n_i;
      sen_s <= sen_m;
      sysref_m <= sysref_i;
      sysref_s <= sysref_m;
      sysref_d <= sysref_s;
      sync_m <= sync_i;
      sync_s <= sync_m;
      sync_d <= sync_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_d; // serial clock rising edge
  wire sclk_fall = ~sclk_s & sclk_d; // serial clock falling edge

  ////////////////////////////////////////////////////////////////////////////////
  // register file and serial port
  reg [7:0] reg_pattern; // test pattern control
  reg [7:0] reg_link; // subclass, scrambler, lane format
  reg [7:0] reg_kcfg; // frames per multiframe minus one
  reg [7:0] reg_align; // multiframe counter start and alignment delay
  reg [3:0] spi_cnt; // bit position in the 16-bit frame
  reg [14:0] spi_sh; // bits received so far
  reg [7:0] spi_rd; // read data being shifted out
  reg spi_read; // current frame is a read
  reg [7:0] rd_mux; // register read selection
  reg [1:0] state; // link state
  reg [4:0] lmfc_cnt; // frame count within multiframe

  wire [6:0] rd_addr = {spi_sh[5:0], sdata_s}; // address complete at eighth bit

  // read selection, unmapped addresses read zero
  always @*
  begin
    case (rd_addr)
      `JTX_ADDR_PATTERN: rd_mux = reg_pattern;
      `JTX_ADDR_LINK: rd_mux = reg_link;
      `JTX_ADDR_KCFG: rd_mux = reg_kcfg;
      `JTX_ADDR_STATUS: rd_mux = {lmfc_cnt, sync_s, state};
      `JTX_ADDR_ALIGN: rd_mux = reg_align;
      default: rd_mux = 8'h00;
    endcase
  end

  // frame shifter: read flag, 7-bit address, 8-bit data, msb first
  always @(posedge sys_clk_i)
  begin
    if (rst_i || sen_s)
    begin
      spi_cnt <= 4'h0;
      spi_sh <= 15'h0000;
      spi_rd <= 8'h00;
      spi_read <= 1'b0;
      sdout_o <= 1'b0;
    end
    else if (sclk_rise)
    begin
      spi_cnt <= spi_cnt + 4'h1;
      spi_sh <= {spi_sh[13:0], sdata_s};
      if (spi_cnt == 4'h7)
      begin
        spi_read <= spi_sh[6];
        spi_rd <= rd_mux;
      end
    end
    else if (sclk_fall && spi_read)
    begin
      // read data changes on falling edges, master samples on rising
      sdout_o <= spi_rd[7];
      spi_rd <= {spi_rd[6:0], 1'b0};
    end
  end

  // register writes on the sixteenth rising edge of a write frame
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      reg_pattern <= `JTX_RST_PATTERN;
      reg_link <= `JTX_RST_LINK;
      reg_kcfg <= `JTX_RST_KCFG;
      reg_align <= `JTX_RST_ALIGN;
    end
    else if (sclk_rise && !sen_s && spi_cnt == 4'hF && !spi_sh[14])
    begin
      case (spi_sh[13:7])
        `JTX_ADDR_PATTERN: reg_pattern <= {spi_sh[6:0], sdata_s};
        `JTX_ADDR_LINK: reg_link <= {spi_sh[6:0], sdata_s};
        `JTX_ADDR_KCFG: reg_kcfg <= {spi_sh[6:0], sdata_s};
        `JTX_ADDR_ALIGN: reg_align <= {spi_sh[6:0], sdata_s};
        default: reg_pattern <= reg_pattern;
      endcase
    end
  end

  // decoded configuration fields
  wire [1:0] pat_sel = reg_pattern[`JTX_PAT_MSB:`JTX_PAT_LSB]; // [R11]
  wire [1:0] subclass = reg_link[`JTX_LINK_SUB_MSB:`JTX_LINK_SUB_LSB];
  wire scr_en = reg_link[`JTX_LINK_SCR];
  wire four_lane = reg_link[`JTX_LINK_FOUR];
  wire [4:0] k_m1 = reg_kcfg[`JTX_KCFG_MSB:0];
  wire force_start_count = reg_align[`JTX_ALIGN_FORCE];
  wire [4:0] multiframe_counter_start_value = reg_align[`JTX_ALIGN_INIT_MSB:`JTX_ALIGN_INIT_LSB];
  wire [1:0] alignment_sequence_delay = reg_align[`JTX_ALIGN_DLY_MSB:`JTX_ALIGN_DLY_LSB];

  ////////////////////////////////////////////////////////////////////////////////
  // transport layer
  reg [14:0] prbs; // pattern generator state
  reg [15:0] src_a, src_b; // selected words per channel
  reg [15:0] hold_a, hold_b; // low octets kept for second frame octet
  reg frame_ph; // octet within frame, two-lane format only

  // advance the 2^15-1 generator by sixteen bits
  function [30:0] prbs_step;
    input [14:0] st;
    reg [14:0] s;
    reg [15:0] w;
    integer i;
    begin
      s = st;
      w = 16'h0000;
      for (i = 15; i >= 0; i = i - 1)
      begin
        w[i] = s[14] ^ s[13];
        s = {s[13:0], s[14] ^ s[13]};
      end
      prbs_step = {s, w};
    end
  endfunction

  wire [30:0] prbs_nx = prbs_step(prbs);

  // data or test pattern feeds the rest of the path
  always @*
  begin
    case (pat_sel) // [R4] [R11]
      `JTX_PAT_CLOCK:
      begin
        src_a = `JTX_CLOCK_WORD;
        src_b = `JTX_CLOCK_WORD;
      end
      `JTX_PAT_ENCODED:
      begin
        src_a = `JTX_ENCODED_WORD;
        src_b = `JTX_ENCODED_WORD;
      end
      `JTX_PAT_PRBS:
      begin
        src_a = prbs_nx[15:0];
        src_b = prbs_nx[15:0];
      end
      default:
      begin
        src_a = adc_a_i;
        src_b = adc_b_i;
      end
    endcase
  end

  // capture once per frame for the two-octet format
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      prbs <= `JTX_PRBS_SEED;
      hold_a <= 16'h0000;
      hold_b <= 16'h0000;
    end
    else if (!frame_ph)
    begin
      prbs <= prbs_nx[30:16];
      hold_a <= src_a;
      hold_b <= src_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // frame and multiframe timing
  wire frame_end = four_lane | frame_ph; // last octet of a frame
  wire mf_end = frame_end & (lmfc_cnt == k_m1); // multiframe boundary follows [R14]
  wire align_ev = (subclass == 2'h1 && sysref_s && !sysref_d)
                  || (subclass == 2'h2 && sync_s && !sync_d); // [R1] [R2]

  // octet phase and multiframe counter
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      frame_ph <= 1'b0;
      lmfc_cnt <= 5'h00;
    end
    else if (align_ev)
    begin
      // realign phase to this sampling edge [R2]
      frame_ph <= 1'b0;
      lmfc_cnt <= force_start_count ? multiframe_counter_start_value : 5'h00; // [R16] [R17]
    end
    else
    begin
      frame_ph <= four_lane ? 1'b0 : ~frame_ph;
      if (frame_end)
        lmfc_cnt <= (lmfc_cnt == k_m1) ? 5'h00 : lmfc_cnt + 5'h01; // [R14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link state machine
  localparam [1:0] ST_CGS = 2'h0; // commas
  localparam [1:0] ST_WAIT = 2'h1; // commas during extra delay
  localparam [1:0] ST_ILAS = 2'h2; // alignment sequence
  localparam [1:0] ST_DATA = 2'h3; // user data
  reg [1:0] next_state;
  reg [1:0] mf_cnt, next_mf_cnt; // multiframe count within delay or sequence

  always @*
  begin
    next_state = state;
    next_mf_cnt = mf_cnt;
    case (state)
      ST_CGS:
        if (!sync_s && mf_end) // [R8] [R16]
        begin
          next_state = (alignment_sequence_delay == 2'h0) ? ST_ILAS : ST_WAIT; // [R15]
          next_mf_cnt = alignment_sequence_delay - 2'h1;
          if (alignment_sequence_delay == 2'h0)
            next_mf_cnt = 2'h0;
        end
      ST_WAIT:
        if (mf_end)
        begin
          next_state = (mf_cnt == 2'h0) ? ST_ILAS : ST_WAIT; // [R15]
          next_mf_cnt = mf_cnt - 2'h1;
          if (mf_cnt == 2'h0)
            next_mf_cnt = 2'h0;
        end
      ST_ILAS:
        if (mf_end)
        begin
          next_state = (mf_cnt == `JTX_ILAS_LAST_MF) ? ST_DATA : ST_ILAS; // [R9]
          next_mf_cnt = mf_cnt + 2'h1;
        end
      ST_DATA:
        next_state = ST_DATA;
      default:
        next_state = ST_CGS;
    endcase
    if (sync_s)
    begin
      // a sync request always returns to commas [R7]
      next_state = ST_CGS;
      next_mf_cnt = 2'h0;
    end
  end

  // state registers
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_CGS;
      mf_cnt <= 2'h0;
    end
    else
    begin
      state <= next_state;
      mf_cnt <= next_mf_cnt;
    end
  end

  wire [5:0] oct_idx = four_lane ? {1'b0, lmfc_cnt} : {lmfc_cnt, frame_ph}; // octet in multiframe

  ////////////////////////////////////////////////////////////////////////////////
  // lane coding functions

  // self-synchronous scrambler 1 + x^14 + x^15, msb first
  function [22:0] scramble;
    input [7:0] d;
    input [14:0] st;
    reg [14:0] s;
    reg [7:0] o;
    integer i;
    begin
      s = st;
      o = 8'h00;
      for (i = 7; i >= 0; i = i - 1)
      begin
        o[i] = d[i] ^ s[14] ^ s[13];
        s = {s[13:0], o[i]};
      end
      scramble = {s, o};
    end
  endfunction

  // configuration octet n of the second multiframe, last one is the checksum
  function [7:0] cfg_octet;
    input [3:0] n;
    input [7:0] lid;
    reg [7:0] lm1, fm1;
    begin
      lm1 = four_lane ? 8'h03 : 8'h01;
      fm1 = four_lane ? 8'h00 : 8'h01;
      case (n)
        4'h0: cfg_octet = `JTX_DID;
        4'h1: cfg_octet = `JTX_BID;
        4'h2: cfg_octet = lid;
        4'h3: cfg_octet = {scr_en, 2'h0, lm1[4:0]};
        4'h4: cfg_octet = fm1;
        4'h5: cfg_octet = {3'h0, k_m1};
        4'h6: cfg_octet = `JTX_M_M1;
        4'h7: cfg_octet = `JTX_N_M1;
        4'h8: cfg_octet = {1'b0, subclass, 5'h00} | `JTX_NP_M1;
        4'h9: cfg_octet = (`JTX_JESDV << 5) | `JTX_S_M1;
        4'hD: cfg_octet = `JTX_DID + `JTX_BID + lid + {7'h00, scr_en} + lm1 + fm1
                          + {3'h0, k_m1} + `JTX_M_M1 + `JTX_N_M1 + `JTX_NP_M1
                          + {6'h00, subclass} + `JTX_JESDV + `JTX_S_M1;
        default: cfg_octet = 8'h00;
      endcase
    end
  endfunction

  // 5b/6b codes at negative disparity, entry n sits at bits 6n+5..6n
  localparam [191:0] S6_TAB = {6'h2B, 6'h1E, 6'h2E, 6'h0E, 6'h36, 6'h16, 6'h26, 6'h33,
    6'h3A, 6'h1A, 6'h2A, 6'h0B, 6'h32, 6'h13, 6'h23, 6'h1B,
    6'h17, 6'h1C, 6'h2C, 6'h0D, 6'h34, 6'h15, 6'h25, 6'h39,
    6'h38, 6'h19, 6'h29, 6'h35, 6'h31, 6'h2D, 6'h1D, 6'h27};

  // 8b/10b: result is {running disparity after, jhgf iedcba}
  function [10:0] encode;
    input [7:0] d;
    input kf;
    input rd;
    reg [5:0] s6;
    reg [3:0] s4;
    reg [2:0] w6, w4;
    reg rdm, alt;
    begin
      s6 = S6_TAB[d[4:0] * 6 +: 6];
      if (kf)
        s6 = 6'h0F;
      w6 = s6[0] + s6[1] + s6[2] + s6[3] + s6[4] + s6[5];
      if (rd && (w6 != 3'h3 || s6 == 6'h38))
        s6 = ~s6;
      rdm = (w6 != 3'h3) ? ~rd : rd;
      alt = (d[7:5] == 3'h7) && (kf || (!rdm && (d[4:0] == 5'h11 || d[4:0] == 5'h12
            || d[4:0] == 5'h14)) || (rdm && (d[4:0] == 5'h0B || d[4:0] == 5'h0D
            || d[4:0] == 5'h0E)));
      case (d[7:5])
        3'h0: s4 = 4'hB;
        3'h1: s4 = 4'h9;
        3'h2: s4 = 4'h5;
        3'h3: s4 = 4'hC;
        3'h4: s4 = 4'hD;
        3'h5: s4 = 4'hA;
        3'h6: s4 = 4'h6;
        default: s4 = alt ? 4'h7 : 4'hE;
      endcase
      w4 = s4[0] + s4[1] + s4[2] + s4[3];
      if (rdm && (w4 != 3'h2 || s4 == 4'hC))
        s4 = ~s4;
      else if (kf && !rdm && w4 == 3'h2 && d[7:5] != 3'h3)
        s4 = ~s4;
      encode = {(w4 != 3'h2) ? ~rdm : rdm, s4[0], s4[1], s4[2], s4[3],
                s6[0], s6[1], s6[2], s6[3], s6[4], s6[5]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // per-lane octet selection, scrambling and coding
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_lane
      localparam [7:0] LANE_ID = gi;
      wire on = four_lane | (gi < 2); // [R3]
      wire [15:0] cur = (four_lane ? (gi >= 2) : (gi == 1)) ? src_b : src_a;
      wire [15:0] held = (gi == 1) ? hold_b : hold_a;
      // one octet per frame per lane, or msb then lsb over two [R12] [R13]
      wire [7:0] dat = four_lane ? ((gi % 2 == 1) ? cur[7:0] : cur[15:8])
                                 : (frame_ph ? held[7:0] : cur[15:8]);
      reg [14:0] scr_st; // scrambler history
      reg rd; // running disparity, 1 is positive
      reg [7:0] oct; // octet to encode
      reg kf; // octet is a control character
      reg [9:0] sym; // registered symbol
      reg en; // registered lane enable
      wire [22:0] scr_nx = scramble(dat, scr_st);
      wire [10:0] code = encode(oct, kf, rd);

      // octet source by link state
      always @*
      begin
        oct = `JTX_K_COMMA; // [R7]
        kf = 1'b1;
        case (state)
          ST_ILAS:
            if (oct_idx == 6'h00)
              oct = `JTX_K_START; // [R10]
            else if (mf_end)
              oct = `JTX_K_END; // [R10]
            else if (mf_cnt == `JTX_CFG_MF && oct_idx == 6'h01)
              oct = `JTX_K_CFG; // [R10]
            else if (mf_cnt == `JTX_CFG_MF && oct_idx >= `JTX_CFG_FIRST
                     && oct_idx <= `JTX_CFG_LAST)
            begin
              oct = cfg_octet(oct_idx[3:0] - 4'h2, LANE_ID); // [R10]
              kf = 1'b0;
            end
            else
            begin
              oct = {2'h0, oct_idx};
              kf = 1'b0;
            end
          ST_DATA:
          begin
            oct = scr_en ? scr_nx[7:0] : dat; // [R6]
            kf = 1'b0;
          end
          default:
            kf = 1'b1;
        endcase
      end

      // symbol, disparity and scrambler registers
      always @(posedge sys_clk_i)
      begin
        if (rst_i)
        begin
          scr_st <= 15'h0000;
          rd <= 1'b0;
          sym <= 10'h000;
          en <= 1'b0;
        end
        else
        begin
          en <= on;
          if (state == ST_DATA && scr_en)
            scr_st <= scr_nx[22:8]; // [R6]
          if (on)
          begin
            sym <= code[9:0]; // [R5]
            rd <= code[10]; // [R5]
          end
          else
            sym <= 10'h000;
        end
      end

      assign lane_sym_o[gi*10 +: 10] = sym;
      assign lane_en_o[gi] = en;
    end
  endgenerate

endmodule // jtx_link_tx

`default_nettype wire

/* File: jtx_link_tx_props.sv */
// assertion checker watching the lane transmitter ports
`timescale 1ns/100ps
`default_nettype none
module jtx_link_tx_props (
  // every port of the transmitter, watched only
  input wire sys_clk_i, rst_i, sysref_i, sync_i, sclk_i, sdata_i, sen_n_i, sdout_o,
  input wire [15:0] adc_a_i, adc_b_i,
  input wire [39:0] lane_sym_o,
  input wire [3:0] lane_en_o
);
  // ten-bit control symbols at negative disparity
  localparam [9:0] SYM_COMMA = 10'h17C;
  localparam [9:0] SYM_START = 10'h0BC;
  localparam [9:0] SYM_END = 10'h33C;
  localparam [9:0] SYM_CFG = 10'h13C;
  wire [9:0] s0 = lane_sym_o[9:0]; // lane 0 symbol
  wire [9:0] s1 = lane_sym_o[19:10]; // lane 1 symbol
  // symbol matches a control symbol of either disparity
  function automatic bit isk(input logic [9:0] s, n);
    return (s == n) || (s == ~n);
  endfunction
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  property p_lane_en_legal;
    !$past(rst_i) |-> (lane_en_o == 4'hF) || (lane_en_o == 4'h3);
  endproperty
  a_lane_en_legal: assert property (p_lane_en_legal) else $error("lane enables illegal");
  property p_unused_quiet;
    lane_en_o == 4'h3 |-> lane_sym_o[39:20] == 20'h00000;
  endproperty
  a_unused_quiet: assert property (p_unused_quiet) else $error("idle lanes not quiet");
  property p_dc_balance;
    lane_en_o[0] |-> $countones(s0) inside {4, 5, 6};
  endproperty
  a_dc_balance: assert property (p_dc_balance) else $error("lane 0 symbol unbalanced");
  property p_comma_sync;
    sync_i [*6] |-> isk(s0, SYM_COMMA) && isk(s1, SYM_COMMA)
      && (!lane_en_o[2] || isk(lane_sym_o[29:20], SYM_COMMA));
  endproperty
  a_comma_sync: assert property (p_comma_sync) else $error("no commas under sync");
  property p_resync;
    $rose(sync_i) |-> ##[1:8] isk(s0, SYM_COMMA);
  endproperty
  a_resync: assert property (p_resync) else $error("sync did not restart commas");
  property p_ilas_start;
    $past(isk(s0, SYM_COMMA)) && !isk(s0, SYM_COMMA) && lane_en_o[0] |-> isk(s0, SYM_START);
  endproperty
  a_ilas_start: assert property (p_ilas_start) else $error("alignment not opened");
  property p_end_before_start;
    isk(s0, SYM_START) && !$past(isk(s0, SYM_COMMA)) |-> $past(isk(s0, SYM_END));
  endproperty
  a_end_before_start: assert property (p_end_before_start) else $error("no frame end");
  property p_cfg_marker;
    isk(s0, SYM_CFG) |-> $past(isk(s0, SYM_START));
  endproperty
  a_cfg_marker: assert property (p_cfg_marker) else $error("config marker misplaced");
  // main scenarios reached
  c_ilas: cover property ($past(isk(s0, SYM_COMMA)) && isk(s0, SYM_START));
  c_cfg: cover property (isk(s0, SYM_CFG));
  c_two_lane: cover property (lane_en_o == 4'h3);
endmodule // jtx_link_tx_props
bind jtx_link_tx jtx_link_tx_props u_props (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .adc_a_i(adc_a_i), .adc_b_i(adc_b_i), .sysref_i(sysref_i), .sync_i(sync_i),
  .sclk_i(sclk_i), .sdata_i(sdata_i), .sen_n_i(sen_n_i), .sdout_o(sdout_o),
  .lane_sym_o(lane_sym_o), .lane_en_o(lane_en_o));
`default_nettype wire

/* File: jtx_rx_model.sv */
// behavioural lane receiver: requests sync, releases it after steady commas
`timescale 1ns/100ps
`default_nettype none
module jtx_rx_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // testbench control: keep requesting sync
  input wire logic hold_i,
  // lanes from the transmitter
  input wire logic [39:0] lane_sym_i,
  input wire logic [3:0] lane_en_i,
  // sync request, high asks for commas
  output logic sync_o
);
  logic [3:0] good_cnt; // consecutive all-comma cycles
  logic all_comma; // every enabled lane shows a comma
  integer i;
  ////////////////////////////////////////////////////////////////////////////////
  // comma detector over the enabled lanes
  always @*
  begin
    all_comma = lane_en_i[0];
    for (i = 0; i < 4; i = i + 1)
      if (lane_en_i[i] && !(lane_sym_i[10*i +: 10] inside {10'h17C, 10'h283}))
        all_comma = 1'b0;
  end
  // sync request and release
  always @(posedge sys_clk_i)
  begin
    if (rst_i || hold_i)
    begin
      sync_o <= 1'b1; // ask for code group sync
      good_cnt <= 4'h0;
    end
    else if (sync_o)
    begin
      good_cnt <= all_comma ? good_cnt + 4'h1 : 4'h0;
      if (good_cnt == 4'h7)
        sync_o <= 1'b0; // locked, release for alignment
    end
  end
endmodule // jtx_rx_model
`default_nettype wire

/* File: tb_jtx_link_tx.sv */
// self-checking testbench for the lane transmitter
`timescale 1ns/100ps
`default_nettype none
`include "jtx_consts.vh"
module tb_jtx_link_tx;
  logic sys_clk_i = 1'b0;
  logic rst_i, sysref_i, sclk_i, sdata_i, sen_n_i, hold; // driven inputs
  logic [15:0] adc_a_i, adc_b_i; // sample ramps
  wire sync_i, sdout_o;
  wire [39:0] lane_sym_o;
  wire [3:0] lane_en_o;
  integer error_cnt = 0, n_checks = 0, cyc = 0, ts, r0, r, ml;
  logic [7:0] rd;
  jtx_link_tx dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .adc_a_i(adc_a_i), .adc_b_i(adc_b_i),
    .sysref_i(sysref_i), .sync_i(sync_i), .sclk_i(sclk_i), .sdata_i(sdata_i), .sen_n_i(sen_n_i),
    .sdout_o(sdout_o), .lane_sym_o(lane_sym_o), .lane_en_o(lane_en_o));
  jtx_rx_model u_rx (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .hold_i(hold),
    .lane_sym_i(lane_sym_o), .lane_en_i(lane_en_o), .sync_o(sync_i));
  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial
  begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  // cycle count and moving samples
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    adc_a_i <= adc_a_i + 16'h0101;
    adc_b_i <= adc_b_i - 16'h0003;
  end
  function automatic logic [9:0] sym(input integer n);
    return lane_sym_o[10*n +: 10];
  endfunction
  function automatic logic isk(input logic [9:0] s, input logic [9:0] n);
    return (s === n) || (s === ~n);
  endfunction
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_sim;
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // one 16-bit register frame, msb first, read bits gathered before each rise
  task spi(input logic [15:0] w, output logic [7:0] q);
    integer i;
    q = 8'h00;
    @(posedge sys_clk_i) sen_n_i <= 1'b0;
    for (i = 15; i >= 0; i = i - 1)
    begin
      @(posedge sys_clk_i) sclk_i <= 1'b0;
      sdata_i <= w[i];
      repeat (6) @(posedge sys_clk_i);
      if (i < 8) q[i] = sdout_o;
      sclk_i <= 1'b1;
      repeat (5) @(posedge sys_clk_i);
    end
    sen_n_i <= 1'b1;
    @(posedge sys_clk_i) sclk_i <= 1'b0;
  endtask
  task pulse_sysref;
    @(posedge sys_clk_i) sysref_i <= 1'b1;
    ts = cyc;
    repeat (4) @(posedge sys_clk_i);
    sysref_i <= 1'b0;
  endtask
  task sync_pulse;
    @(posedge sys_clk_i) hold <= 1'b1;
    @(posedge sys_clk_i) hold <= 1'b0;
  endtask
  // full resync with alignment delay d; q is the start phase against sysref
  task run_ilas(input integer d, output integer q);
    integer i, n, tr, t0;
    logic [9:0] b [0:160];
    sync_pulse;
    repeat (6) @(negedge sys_clk_i);
    chk("commas", isk(sym(0), 10'h17C) && isk(sym(1), 10'h17C), 16'h1);
    for (n = 0; sync_i !== 1'b0 && n < 100; n = n + 1) @(negedge sys_clk_i);
    tr = cyc;
    for (n = 0; !isk(sym(0), 10'h0BC) && n < 300; n = n + 1) @(negedge sys_clk_i);
    t0 = cyc;
    chk("lane1 start", isk(sym(1), 10'h0BC), 16'h1);
    for (i = 0; i <= 4 * ml; i = i + 1)
    begin
      b[i] = sym(0);
      @(negedge sys_clk_i);
    end
    for (i = 0; i < 4; i = i + 1)
    begin
      chk("mf start", isk(b[i*ml], 10'h0BC), 16'h1);
      chk("mf end", isk(b[i*ml+ml-1], 10'h33C), 16'h1);
    end
    chk("cfg mark", isk(b[ml+1], 10'h13C), 16'h1);
    chk("data after", isk(b[4*ml], 10'h0BC), 16'h0);
    chk("delay", (t0 - tr > d * ml) && (t0 - tr <= (d + 1) * ml + 6), 16'h1);
    q = (t0 - ts) % ml;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    spi({1'b1, `JTX_ADDR_PATTERN, 8'h00}, rd);
    chk("pattern reset", rd, `JTX_RST_PATTERN);
    spi({1'b0, `JTX_ADDR_PATTERN, 8'hC0}, rd);
    spi({1'b1, `JTX_ADDR_PATTERN, 8'h00}, rd);
    chk("pattern rw", rd, 16'h00C0);
    spi({1'b1, 7'h50, 8'h00}, rd);
    chk("unmapped", rd, 16'h0000);
    spi({1'b0, `JTX_ADDR_KCFG, 8'h13}, rd);
    ml = 20;
  endtask
  // every delay setting keeps the multiframe phase set by sysref
  task t_align;
    integer d;
    pulse_sysref;
    for (d = 0; d < 4; d = d + 1)
    begin
      spi({1'b0, `JTX_ADDR_ALIGN, 8'(d)}, rd);
      run_ilas(d, r);
      if (d == 0)
        r0 = r;
      else
        chk("mf phase", r, r0);
    end
  endtask
  task t_force;
    spi({1'b0, `JTX_ADDR_ALIGN, 8'h94}, rd);
    pulse_sysref;
    run_ilas(0, r);
    chk("forced phase", r, (r0 + ml - 5) % ml);
    spi({1'b0, `JTX_ADDR_ALIGN, 8'h00}, rd);
  endtask
  // sync raised again in mid alignment
  task t_abort;
    integer n;
    sync_pulse;
    for (n = 0; !isk(sym(0), 10'h0BC) && n < 300; n = n + 1) @(negedge sys_clk_i);
    repeat (5) @(negedge sys_clk_i);
    sync_pulse;
    repeat (8) @(negedge sys_clk_i);
    chk("abort comma", isk(sym(0), 10'h17C), 16'h1);
  endtask
  task t_pattern;
    integer i, n;
    run_ilas(0, r);
    spi({1'b0, `JTX_ADDR_PATTERN, 8'h40}, rd);
    repeat (4) @(negedge sys_clk_i);
    for (i = 0; i < 4; i = i + 1)
      chk("clock word", sym(i), 16'h016A);
    spi({1'b0, `JTX_ADDR_LINK, 8'h0D}, rd);
    n = 0;
    for (i = 0; i < 8; i = i + 1)
    begin
      @(negedge sys_clk_i);
      if (sym(0) !== 10'h16A) n = n + 1;
    end
    chk("scrambled", n > 0, 16'h1);
    spi({1'b0, `JTX_ADDR_LINK, 8'h01}, rd);
    ml = 40;
    run_ilas(0, r);
    repeat (4) @(negedge sys_clk_i);
    chk("two lanes", lane_en_o, 16'h0003);
    chk("two lane data", {sym(0), sym(1)} == {10'h16A, 10'h16A}, 16'h1);
    chk("idle lanes", lane_sym_o[39:20] == 20'h00000, 16'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    rst_i = 1'b1;
    hold = 1'b1;
    sysref_i = 1'b0;
    sclk_i = 1'b0;
    sdata_i = 1'b0;
    sen_n_i = 1'b1;
    adc_a_i = 16'h1234;
    adc_b_i = 16'h8000;
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    t_regs;
    t_align;
    t_force;
    t_abort;
    t_pattern;
    end_sim;
  end
  // watchdog
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    error_cnt = error_cnt + 1;
    end_sim;
  end
endmodule // tb_jtx_link_tx
`default_nettype wire
